// ===== src/irtc_pkg.sv
// Shared constants of the infrared timer common control block.
package irtc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets on the plain register port.
  localparam logic [2:0] OFF_CARRIER_CTRL = 3'h0;
  localparam logic [2:0] OFF_COMMON_CTRL = 3'h1;
  localparam logic [2:0] OFF_WIDE_CTRL = 3'h2;
  localparam logic [2:0] OFF_SYNC_CTRL = 3'h3;
  localparam logic [2:0] OFF_INT_STATUS = 3'h4;
  localparam logic [2:0] OFF_INT_MASK = 3'h5;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions of the common control, sync control and interrupt registers.
  localparam int BIT_WIDE_INIT = 7;
  localparam int BIT_CARRIER_INIT = 6;
  localparam int OMODE_LSB = 4;
  localparam int LOGIC_LSB = 2;
  localparam int BIT_PIN_SEL = 1;
  localparam int BIT_MODE = 0;
  localparam int BIT_SYNC_EN = 7;
  localparam int INT_FALL = 0;
  localparam int INT_RISE = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Field encodings and reset values.
  localparam logic MODE_TRANSMIT = 1'h0;
  localparam logic MODE_DEMOD = 1'h1;
  localparam logic [1:0] OMODE_NORMAL = 2'h0;
  localparam logic [1:0] OMODE_ALT = 2'h1;
  localparam logic [1:0] OMODE_FORCE0 = 2'h2;
  localparam logic [1:0] OMODE_FORCE1 = 2'h3;
  localparam logic [1:0] FILT_NONE = 2'h0;
  localparam logic [1:0] FILT_4 = 2'h1;
  localparam logic [1:0] FILT_8 = 2'h2;
  localparam logic [1:0] LOGIC_AND = 2'h0;
  localparam logic [1:0] LOGIC_OR = 2'h1;
  localparam logic [1:0] LOGIC_NOR = 2'h2;
  localparam logic [1:0] LOGIC_NAND = 2'h3;
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [1:0] INT_RST = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Filter lengths in system clocks.
  localparam logic [3:0] FILT_4_CLKS = 4'h4;
  localparam logic [3:0] FILT_8_CLKS = 4'h8;

endpackage : irtc_pkg

// ===== src/irtc_edge_if.sv
`timescale 1ns/1ps
// Carries demodulator settings to the edge detector and its edge events back.
interface irtc_edge_if;
  logic demod_en;
  logic src_sel;
  logic [1:0] filt_sel;
  logic [1:0] edge_sel;
  logic rise_evt;
  logic fall_evt;

  modport ctl (output demod_en, output src_sel, output filt_sel, output edge_sel,
               input rise_evt, input fall_evt);
  modport det (input demod_en, input src_sel, input filt_sel, input edge_sel,
               output rise_evt, output fall_evt);
endinterface : irtc_edge_if

// ===== src/irtc_edge_det.sv
`timescale 1ns/1ps
// Demodulator input select, noise filter and edge detection.
module irtc_edge_det (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic port3_pin1,
  input wire logic port2_pin0,
  irtc_edge_if.det intf
);

  typedef struct packed {
    logic lvl;
    logic [3:0] cnt;
    logic rise;
    logic fall;
  } irtc_det_t;

  irtc_det_t st_r;
  irtc_det_t st_nxt;
  logic raw;
  logic [3:0] need;
  logic [3:0] ce_run_r;

  assign raw = intf.src_sel ? port2_pin0 : port3_pin1;

  ////////////////////////////////////////////////////////////////////////////
  // filtered level tracks the pin once it holds for the filter length.
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rise = 1'h0;
    st_nxt.fall = 1'h0;
    need = (intf.filt_sel == irtc_pkg::FILT_8) ? irtc_pkg::FILT_8_CLKS : irtc_pkg::FILT_4_CLKS;
    if (raw == st_r.lvl)
    begin
      st_nxt.cnt = 4'h0;
    end
    else if (intf.filt_sel == irtc_pkg::FILT_NONE || st_r.cnt + 4'h1 >= need)
    begin
      st_nxt.cnt = 4'h0;
      st_nxt.lvl = raw;
      // edge type selection gates the events.
      if (intf.demod_en)
      begin
        st_nxt.rise = raw && (intf.edge_sel == irtc_pkg::EDGE_RISE ||
                              intf.edge_sel == irtc_pkg::EDGE_BOTH);
        st_nxt.fall = !raw && (intf.edge_sel == irtc_pkg::EDGE_FALL ||
                               intf.edge_sel == irtc_pkg::EDGE_BOTH);
      end
    end
    else
    begin
      st_nxt.cnt = st_r.cnt + 4'h1;
    end
  end

  // State register, frozen while the clock enable is low; the enable run count ce_run_r clears then.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
      ce_run_r <= 4'h0;
    end
    else
    begin
      ce_run_r <= !ce ? 4'h0 : (ce_run_r == 4'hF ? ce_run_r : ce_run_r + 4'h1);
      if (ce)
      begin
        st_r <= st_nxt;
      end
    end
  end

  assign intf.rise_evt = st_r.rise;
  assign intf.fall_evt = st_r.fall;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the filter and the event gating.
  a_filter_four: assert property (@(posedge clk) disable iff (!rst_n)
    ($changed(st_r.lvl) && ce_run_r >= 4'h8 && intf.filt_sel == irtc_pkg::FILT_4 &&
     $stable(intf.filt_sel) && $stable(intf.src_sel))
    |-> ($past(raw, 1) == st_r.lvl && $past(raw, 4) == st_r.lvl))
    else $error("Filtered level changed before the input held four clocks.");
  a_no_evt_tx: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && !intf.demod_en) |=> (!intf.rise_evt && !intf.fall_evt))
    else $error("Edge event raised outside demodulation mode.");
  c_rise_seen: cover property (@(posedge clk) disable iff (!rst_n) intf.rise_evt);

endmodule : irtc_edge_det

// ===== src/irtc_top.sv
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
// Contract
// - Mode bit selects transmit at 0, demodulation at 1; transmit after reset.
// - Transmit mode: one bit sets the wide timer output start level.
// - Transmit mode: another bit sets the carrier timer output start level.
// - Demodulation mode: wide level bit reads falling edge flag; write 1 clears.
// - Demodulation mode: carrier level bit reads rising edge flag; write 1 clears.
// - Field selects normal, alternating, force 0, force 1; or filter none/4/8.
// - Field selects AND, OR, NOR, NAND; or falling, rising, both edges.
// - Transmit mode: pin select drives port pin with combined output.
// - Demodulation mode: pin select picks port 3 or port 2 input.
// - Sync mode aligns first carrier pulse to wide timer output.
// - Double-default fields reset only on reset, kept over stop recovery.
module irtc_top #(
  parameter int ADDR_W = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  output logic irq,
  input wire logic stop_recover,
  input wire logic wide_timer_output,
  input wire logic carrier_timer_output,
  input wire logic port3_pin1,
  input wire logic port2_pin0,
  input wire logic port3_pin6_port_data,
  output logic port3_pin6,
  output logic combined_timer_output,
  output logic demod_mode,
  output logic wide_init_level,
  output logic carrier_init_level,
  output logic alternating_timer_mode,
  output logic wide_force_en,
  output logic wide_force_level,
  output logic carrier_sync_restart,
  output logic [7:0] carrier_timer_control,
  output logic [7:0] wide_timer_control,
  output logic [7:0] timer_sync_control
);

  if (ADDR_W < 3 || ADDR_W > 8)
  begin : g_bad_addr
    $error("ADDR_W must lie between 3 and 8.");
  end

  typedef struct packed {
    logic mode;
    logic wide_init;
    logic carrier_init;
    logic [1:0] omode;
    logic [1:0] logic_sel;
    logic pin_sel;
    logic fall_flag;
    logic rise_flag;
    logic [7:0] carrier_ctrl;
    logic [7:0] wide_ctrl;
    logic [7:0] sync_ctrl;
    logic [1:0] int_stat;
    logic [1:0] int_mask;
    logic [7:0] rdata;
    logic irq;
    logic pin_out;
    logic comb_out;
    logic wide_prev;
    logic restart;
    logic alt;
    logic force_en;
    logic force_lvl;
  } irtc_regs_t;

  irtc_regs_t st_r;
  irtc_regs_t st_nxt;
  irtc_edge_if edge_bus ();
  logic [2:0] reg_addr;
  logic tx_mode;
  logic wide_eff;
  logic comb;
  logic [7:0] common_rd;

  assign reg_addr = addr[2:0];
  assign tx_mode = (st_r.mode == irtc_pkg::MODE_TRANSMIT);

  ////////////////////////////////////////////////////////////////////////////
  // Edge detector and the settings it takes from the common control register.

  // filter field feeds the detector in demodulation mode.
  assign edge_bus.demod_en = (st_r.mode == irtc_pkg::MODE_DEMOD);
  assign edge_bus.src_sel = st_r.pin_sel;
  assign edge_bus.filt_sel = st_r.omode;
  assign edge_bus.edge_sel = st_r.logic_sel;

  irtc_edge_det u_edge (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .port3_pin1(port3_pin1),
    .port2_pin0(port2_pin0),
    .intf(edge_bus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Transmit output path.

  // forced levels override the wide timer output in transmit mode.
  always_comb
  begin
    wide_eff = wide_timer_output;
    if (tx_mode && st_r.omode == irtc_pkg::OMODE_FORCE0)
    begin
      wide_eff = 1'h0;
    end
    else if (tx_mode && st_r.omode == irtc_pkg::OMODE_FORCE1)
    begin
      wide_eff = 1'h1;
    end
  end

  // combining logic of the two timer outputs.
  always_comb
  begin
    case (st_r.logic_sel)
      irtc_pkg::LOGIC_AND: comb = wide_eff & carrier_timer_output;
      irtc_pkg::LOGIC_OR: comb = wide_eff | carrier_timer_output;
      irtc_pkg::LOGIC_NOR: comb = ~(wide_eff | carrier_timer_output);
      irtc_pkg::LOGIC_NAND: comb = ~(wide_eff & carrier_timer_output);
      default: comb = 1'h0;
    endcase
  end

  // Read view of the common control register; bits 7 and 6 depend on the mode.
  always_comb
  begin
    common_rd = 8'h00;
    // falling edge flag shows in place of the wide start level.
    common_rd[irtc_pkg::BIT_WIDE_INIT] = tx_mode ? st_r.wide_init : st_r.fall_flag;
    // rising edge flag shows in place of the carrier start level.
    common_rd[irtc_pkg::BIT_CARRIER_INIT] = tx_mode ? st_r.carrier_init : st_r.rise_flag;
    common_rd[irtc_pkg::OMODE_LSB +: 2] = st_r.omode;
    common_rd[irtc_pkg::LOGIC_LSB +: 2] = st_r.logic_sel;
    common_rd[irtc_pkg::BIT_PIN_SEL] = st_r.pin_sel;
    common_rd[irtc_pkg::BIT_MODE] = st_r.mode;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state: register port, stop recovery, flags and registered outputs.
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rdata = 8'h00;
    st_nxt.restart = 1'h0;
    if (stop_recover)
    begin
      // stop recovery restores single-default fields; logic select is kept.
      st_nxt.mode = irtc_pkg::MODE_TRANSMIT;
      st_nxt.wide_init = 1'h0;
      st_nxt.carrier_init = 1'h0;
      st_nxt.omode = irtc_pkg::OMODE_NORMAL;
      st_nxt.pin_sel = 1'h0;
      st_nxt.fall_flag = 1'h0;
      st_nxt.rise_flag = 1'h0;
    end
    else if (wr_en)
    begin
      case (reg_addr)
        irtc_pkg::OFF_CARRIER_CTRL: st_nxt.carrier_ctrl = wdata;
        irtc_pkg::OFF_WIDE_CTRL: st_nxt.wide_ctrl = wdata;
        irtc_pkg::OFF_SYNC_CTRL: st_nxt.sync_ctrl = wdata;
        irtc_pkg::OFF_INT_MASK: st_nxt.int_mask = wdata[1:0];
        irtc_pkg::OFF_COMMON_CTRL:
        begin
          // mode bit; the shared fields change meaning with it.
          st_nxt.mode = wdata[irtc_pkg::BIT_MODE];
          st_nxt.omode = wdata[irtc_pkg::OMODE_LSB +: 2];
          st_nxt.logic_sel = wdata[irtc_pkg::LOGIC_LSB +: 2];
          st_nxt.pin_sel = wdata[irtc_pkg::BIT_PIN_SEL];
          if (tx_mode)
          begin
            st_nxt.wide_init = wdata[irtc_pkg::BIT_WIDE_INIT];
            st_nxt.carrier_init = wdata[irtc_pkg::BIT_CARRIER_INIT];
          end
          else
          begin
            // writing 1 clears the falling edge flag, 0 leaves it.
            if (wdata[irtc_pkg::BIT_WIDE_INIT])
            begin
              st_nxt.fall_flag = 1'h0;
            end
            // writing 1 clears the rising edge flag, 0 leaves it.
            if (wdata[irtc_pkg::BIT_CARRIER_INIT])
            begin
              st_nxt.rise_flag = 1'h0;
            end
          end
        end
        default: st_nxt.int_mask = st_r.int_mask;
      endcase
    end
    // Read data stands for one cycle only; a status read clears the status.
    if (rd_en)
    begin
      case (reg_addr)
        irtc_pkg::OFF_CARRIER_CTRL: st_nxt.rdata = st_r.carrier_ctrl;
        irtc_pkg::OFF_COMMON_CTRL: st_nxt.rdata = common_rd;
        irtc_pkg::OFF_WIDE_CTRL: st_nxt.rdata = st_r.wide_ctrl;
        irtc_pkg::OFF_SYNC_CTRL: st_nxt.rdata = st_r.sync_ctrl;
        irtc_pkg::OFF_INT_STATUS:
        begin
          st_nxt.rdata = {6'h00, st_r.int_stat};
          st_nxt.int_stat = irtc_pkg::INT_RST;
        end
        irtc_pkg::OFF_INT_MASK: st_nxt.rdata = {6'h00, st_r.int_mask};
        default: st_nxt.rdata = 8'h00;
      endcase
    end
    // edge events set the flags after any clear, so a set wins.
    if (edge_bus.fall_evt)
    begin
      st_nxt.fall_flag = 1'h1;
      st_nxt.int_stat[irtc_pkg::INT_FALL] = 1'h1;
    end
    if (edge_bus.rise_evt)
    begin
      st_nxt.rise_flag = 1'h1;
      st_nxt.int_stat[irtc_pkg::INT_RISE] = 1'h1;
    end
    st_nxt.irq = |(st_nxt.int_stat & st_nxt.int_mask);
    // port pin carries the combined output or the ordinary port data.
    st_nxt.comb_out = comb;
    st_nxt.pin_out = (tx_mode && st_r.pin_sel) ? comb : port3_pin6_port_data;
    // transmit output mode decode for the wide timer.
    st_nxt.alt = tx_mode && st_r.omode == irtc_pkg::OMODE_ALT;
    st_nxt.force_en = tx_mode && st_r.omode[1];
    st_nxt.force_lvl = st_r.omode[0];
    // restart the carrier on each rising edge of the wide output while sync is on in transmit mode.
    st_nxt.wide_prev = wide_timer_output;
    st_nxt.restart = tx_mode && st_r.sync_ctrl[irtc_pkg::BIT_SYNC_EN] &&
                     wide_timer_output && !st_r.wide_prev;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register, frozen while the clock enable is low.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // every field, double-default ones included, clears on reset.
      st_r <= '0;
    end
    else if (ce)
    begin
      st_r <= st_nxt;
    end
  end

  // Outputs taken straight from the state register.
  assign rdata = st_r.rdata;
  assign irq = st_r.irq;
  assign port3_pin6 = st_r.pin_out;
  assign combined_timer_output = st_r.comb_out;
  assign demod_mode = st_r.mode;
  assign wide_init_level = st_r.wide_init;
  assign carrier_init_level = st_r.carrier_init;
  assign alternating_timer_mode = st_r.alt;
  assign wide_force_en = st_r.force_en;
  assign wide_force_level = st_r.force_lvl;
  assign carrier_sync_restart = st_r.restart;
  assign carrier_timer_control = st_r.carrier_ctrl;
  assign wide_timer_control = st_r.wide_ctrl;
  assign timer_sync_control = st_r.sync_ctrl;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the register port, flags and outputs.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_rise_flag_set: assert property (
    (ce && edge_bus.rise_evt && !stop_recover) |=> (st_r.rise_flag && st_r.int_stat[1]))
    else $error("Rising edge event did not set its flags.");
  a_fall_clear: assert property (
    (ce && wr_en && !stop_recover && reg_addr == irtc_pkg::OFF_COMMON_CTRL && !tx_mode &&
     wdata[7] && !edge_bus.fall_evt) |=> !st_r.fall_flag)
    else $error("Falling edge flag survived a write of one.");
  a_read_once: assert property (
    (ce && rd_en && reg_addr == irtc_pkg::OFF_COMMON_CTRL) ##1 (ce && !rd_en)
    |=> (rdata == 8'h00))
    else $error("Read data stood longer than one cycle.");
  a_mode_read: assert property (
    (ce && rd_en && reg_addr == irtc_pkg::OFF_COMMON_CTRL) |=> (rdata[0] == $past(st_r.mode)))
    else $error("Mode bit read back wrong.");
  a_irq_level: assert property (
    (irq == |(st_r.int_stat & st_r.int_mask)))
    else $error("Interrupt output disagrees with status and mask.");
  a_pin_drive: assert property (
    (ce && tx_mode && st_r.pin_sel && !stop_recover) |=> (port3_pin6 == combined_timer_output))
    else $error("Port pin does not carry the combined output.");
  a_force_zero: assert property (
    (ce && tx_mode && st_r.omode == irtc_pkg::OMODE_FORCE0 && st_r.logic_sel == 2'h0)
    |=> !combined_timer_output)
    else $error("Forced low wide output let the AND result rise.");
  a_smr_keep: assert property (
    (ce && stop_recover) |=> (st_r.logic_sel == $past(st_r.logic_sel) && !st_r.mode))
    else $error("Stop recovery changed the logic select or kept the mode.");
  a_sync_restart: assert property (
    (ce && tx_mode && st_r.sync_ctrl[7] && wide_timer_output && !st_r.wide_prev &&
     !stop_recover) |=> carrier_sync_restart)
    else $error("Carrier restart missing on wide output rise.");
  a_tx_init: assert property (
    (ce && wr_en && !stop_recover && reg_addr == irtc_pkg::OFF_COMMON_CTRL && tx_mode)
    |=> (wide_init_level == $past(wdata[7]) && carrier_init_level == $past(wdata[6])))
    else $error("Start levels not taken from a transmit mode write.");
  // rise flag clear on a write of one.
  a_rise_clear: assert property (
    (ce && wr_en && !stop_recover && reg_addr == irtc_pkg::OFF_COMMON_CTRL && !tx_mode &&
     wdata[irtc_pkg::BIT_CARRIER_INIT] && !edge_bus.rise_evt) |=> !st_r.rise_flag)
    else $error("Rising edge flag survived a write of one.");
  a_demod_keep: assert property (
    (ce && wr_en && !stop_recover && reg_addr == irtc_pkg::OFF_COMMON_CTRL && !tx_mode)
    |=> ($stable(wide_init_level) && $stable(carrier_init_level)))
    else $error("Demodulation mode write changed a start level.");
  a_alt_decode: assert property (
    (ce && tx_mode && st_r.omode == irtc_pkg::OMODE_ALT) |=> alternating_timer_mode)
    else $error("Alternating mode output missing in transmit mode.");

  c_irq_raised: cover property ($rose(irq));
  c_demod_fall: cover property (demod_mode && edge_bus.fall_evt);
  c_pin_comb: cover property (tx_mode && st_r.pin_sel && $rose(port3_pin6));
  c_sync_pulse: cover property (carrier_sync_restart);

endmodule : irtc_top

// ===== sim/irtc_ir_model.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Infrared receiver front end that drives the two demodulator input pins.
module irtc_ir_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sel,
  input wire logic level,
  output logic port3_pin1,
  output logic port2_pin0
);
  logic junk_r;

  // The unused pin toggles every cycle, so a wrong input choice shows as edges.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      junk_r <= 1'b0;
    end
    else
    begin
      junk_r <= ~junk_r;
    end
  end

  // The chosen pin carries the wanted level.
  assign port3_pin1 = sel ? junk_r : level;
  assign port2_pin0 = sel ? level : junk_r;
endmodule : irtc_ir_model

// ===== sim/ir_timer_common_control_bench.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Self-checking bench of the infrared timer common control block.
module ir_timer_common_control_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic stop_recover = 1'b0;
  logic ce = 1'h1;
  logic wide_out = 1'b0;
  logic carrier_out = 1'b0;
  logic port_data = 1'b0;
  logic sel = 1'b0;
  logic level = 1'b0;
  logic rd_d = 1'b0;
  logic [7:0] rnd = 8'h62;
  logic p31, p20, pin6, comb, irq, demod, winit, cinit, alt, fen, flev, sync_pulse;
  logic [7:0] rdata, cctl, wctl, sctl;
  logic [7:0] exp_q[$];
  int bad_count = 0;
  int samples_checked = 0;

  always #12.5 clk = ~clk;

  irtc_ir_model i_model (.clk(clk), .rst_n(rst_n), .sel(sel), .level(level),
    .port3_pin1(p31), .port2_pin0(p20));

  irtc_top #(.ADDR_W(3)) i_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq(irq),
    .stop_recover(stop_recover), .wide_timer_output(wide_out),
    .carrier_timer_output(carrier_out), .port3_pin1(p31), .port2_pin0(p20),
    .port3_pin6_port_data(port_data), .port3_pin6(pin6), .combined_timer_output(comb),
    .demod_mode(demod), .wide_init_level(winit), .carrier_init_level(cinit),
    .alternating_timer_mode(alt), .wide_force_en(fen), .wide_force_level(flev),
    .carrier_sync_restart(sync_pulse), .carrier_timer_control(cctl),
    .wide_timer_control(wctl), .timer_sync_control(sctl));

  //////////////////////////////////////////////////////////////////////////////
  // Pseudo-random source for the timer outputs and port data.
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  // Compares register read data.
  task automatic check_val(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check_val

  // Compares a single output level.
  task automatic check_bit(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : check_bit

  // One-cycle register write.
  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : reg_wr

  // One-cycle register read; the expected data waits in the queue.
  task automatic reg_rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    exp_q.push_back(e);
    @(posedge clk);
    rd_en <= 1'b0;
  endtask : reg_rd

  // Holds the demodulator input at a level for a number of cycles.
  task automatic drive_in(input logic v, input int n);
    @(posedge clk);
    level <= v;
    repeat (n) @(posedge clk);
  endtask : drive_in

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  //////////////////////////////////////////////////////////////////////////////
  // Read data is due one cycle after the strobe and is zero otherwise.
  always @(posedge clk)
  begin
    rd_d <= rd_en;
    if (rd_d && exp_q.size() > 0)
      check_val(rdata, exp_q.pop_front(), "read data");
    else if (rst_n)
      check_val(rdata, 8'h00, "idle read data");
  end

  // Cuts a hung run short.
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("MISMATCH t=%0t run did not finish", $time);
    give_verdict();
  end

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    logic [7:0] cv;
    logic [1:0] ev;
    logic we, ec, fl, ri;
    int n;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 8; a++)
      reg_rd(a[2:0], 8'h00);
    reg_wr(3'h0, 8'hA5);
    reg_wr(3'h2, 8'h5A);
    reg_wr(3'h6, 8'hFF);
    reg_rd(3'h0, 8'hA5);
    reg_rd(3'h2, 8'h5A);
    reg_rd(3'h6, 8'h00);
    check_val(cctl, 8'hA5, "carrier control");
    check_val(wctl, 8'h5A, "wide control");
    // every transmit setting with random timer levels.
    for (int c = 0; c < 16; c++)
    begin
      cv = {c[0], c[3], c[3:2], c[1:0], c[2] ^ c[0], 1'b0};
      reg_wr(3'h1, cv);
      reg_rd(3'h1, cv);
      for (int t = 0; t < 4; t++)
      begin
        @(posedge clk);
        rnd = lfsr(rnd);
        wide_out <= rnd[0];
        carrier_out <= rnd[1];
        port_data <= rnd[2];
        repeat (3) @(posedge clk);
        @(negedge clk);
        we = cv[5] ? cv[4] : rnd[0];
        case (cv[3:2])
          2'h0: ec = we & rnd[1];
          2'h1: ec = we | rnd[1];
          2'h2: ec = ~(we | rnd[1]);
          default: ec = ~(we & rnd[1]);
        endcase
        check_bit(comb, ec, "combined output");
        check_bit(pin6, cv[1] ? ec : rnd[2], "output pin");
      end
      check_bit(winit, cv[7], "wide start level");
      check_bit(cinit, cv[6], "carrier start level");
      check_bit(alt, cv[5:4] == 2'h1, "alternating mode");
      check_bit(fen, cv[5], "force enable");
      check_bit(flev, cv[4], "force level");
    end
    // stop recovery keeps the combining choice and the carrier control value.
    reg_wr(3'h1, 8'hFE);
    @(posedge clk);
    stop_recover <= 1'b1;
    @(posedge clk);
    stop_recover <= 1'b0;
    reg_rd(3'h1, 8'h0C);
    reg_rd(3'h0, 8'hA5);
    // a reset in mid-run returns the kept combining choice to AND.
    @(posedge clk);
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    reg_rd(3'h1, 8'h00);
    reg_rd(3'h0, 8'h00);
    // one carrier restart per wide rise, only with sync on.
    for (int s = 0; s < 2; s++)
    begin
      reg_wr(3'h3, {s[0], 7'h00});
      @(posedge clk);
      wide_out <= 1'b0;
      repeat (3) @(posedge clk);
      wide_out <= 1'b1;
      n = 0;
      repeat (6)
      begin
        @(negedge clk);
        if (sync_pulse === 1'b1)
          n++;
      end
      check_val(n[7:0], {7'h00, s[0]}, "restart pulses");
      check_val(sctl, {s[0], 7'h00}, "sync control");
    end
    // timers idle before the mode change.
    @(posedge clk);
    wide_out <= 1'b0;
    carrier_out <= 1'b0;
    reg_wr(3'h5, 8'h03);
    reg_wr(3'h1, 8'h01);
    @(negedge clk);
    check_bit(demod, 1'b1, "demod mode");
    // each edge selection, flags, status and interrupt.
    for (int e = 0; e < 4; e++)
    begin
      ev = e[1:0];
      fl = (ev == 2'h0) || (ev == 2'h2);
      ri = (ev == 2'h1) || (ev == 2'h2);
      reg_wr(3'h1, {4'hC, ev, 2'h1});
      drive_in(1'b1, 6);
      drive_in(1'b0, 6);
      reg_rd(3'h1, {fl, ri, 2'h0, ev, 2'h1});
      @(negedge clk);
      check_bit(irq, fl | ri, "irq raised");
      reg_rd(3'h4, {6'h00, ri, fl});
      repeat (2) @(negedge clk);
      check_bit(irq, 1'b0, "irq cleared");
    end
    // a 4-clock filter rejects a 3-clock pulse; masked flags stay quiet.
    reg_wr(3'h5, 8'h00);
    reg_wr(3'h1, 8'hD5);
    drive_in(1'b1, 2);
    drive_in(1'b0, 8);
    reg_rd(3'h1, 8'h15);
    drive_in(1'b1, 8);
    reg_rd(3'h1, 8'h55);
    check_bit(irq, 1'b0, "masked irq");
    reg_wr(3'h1, 8'h15);
    reg_rd(3'h1, 8'h55);
    reg_rd(3'h4, 8'h02);
    drive_in(1'b0, 8);
    // an 8-clock filter rejects a 7-clock pulse and takes an 11-clock one.
    reg_wr(3'h1, 8'hE5);
    drive_in(1'h1, 6);
    drive_in(1'h0, 8);
    reg_rd(3'h1, 8'h25);
    drive_in(1'h1, 8);
    reg_rd(3'h1, 8'h65);
    drive_in(1'h0, 8);
    // second input pin; the toggling first pin is ignored.
    @(posedge clk);
    sel <= 1'b1;
    reg_wr(3'h1, 8'hC7);
    repeat (8) @(posedge clk);
    reg_rd(3'h1, 8'h07);
    drive_in(1'b1, 6);
    reg_rd(3'h1, 8'h47);
    // A low clock enable drops a register write.
    @(posedge clk);
    ce <= 1'h0;
    reg_wr(3'h0, 8'h3C);
    @(posedge clk);
    ce <= 1'h1;
    reg_rd(3'h0, 8'h00);
    repeat (4) @(posedge clk);
    give_verdict();
  end
endmodule : ir_timer_common_control_bench
